/* shared/pprsp_defines.svh */
// constants of the parallel poll responder: offsets, fields, codes
`ifndef PPRSP_DEFINES_SVH
`define PPRSP_DEFINES_SVH
// register byte offsets
`define PPRSP_ADDR_CTRL 4'h0
`define PPRSP_ADDR_STAT 4'h4
`define PPRSP_ADDR_LAST 4'h8
// control register fields and reset value
`define PPRSP_CTRL_STATUS 0
`define PPRSP_CTRL_RST 32'h0000_0000
// status register fields
`define PPRSP_STAT_IDLE 0
`define PPRSP_STAT_ARMED 1
`define PPRSP_STAT_IDY 2
`define PPRSP_STAT_DRIVE 3
`define PPRSP_STAT_SEL_LO 4
`define PPRSP_STAT_SENSE 7
`define PPRSP_STAT_CAP 8
// interface command codes, logical (true = bus line low)
`define PPRSP_CODE_PPC 7'h05
`define PPRSP_CODE_PPU 7'h15
`define PPRSP_CODE_UNL 7'h3f
`define PPRSP_CODE_PPE_HI 3'h6
`define PPRSP_CODE_PPD 7'h70
// enable byte field positions
`define PPRSP_PPE_SEL_HI 2
`define PPRSP_PPE_SENSE 3
// axi4-lite responses
`define PPRSP_RESP_OKAY 2'b00
`define PPRSP_RESP_DECERR 2'b11
`endif

/* shared/pprsp_pkg.sv */
// types shared by the parallel poll responder
package pprsp_pkg;
  typedef enum logic [1:0]
  {
    PPRSP_ST_IDLE = 2'b01,
    PPRSP_ST_CONF = 2'b10
  } pprsp_state_type;
  typedef enum logic [2:0]
  {
    PPRSP_CMD_OTHER = 3'h0,
    PPRSP_CMD_PPC = 3'h1,
    PPRSP_CMD_PPU = 3'h2,
    PPRSP_CMD_UNL = 3'h3,
    PPRSP_CMD_PPE = 3'h4,
    PPRSP_CMD_PPD = 3'h5
  } pprsp_cmd_type;
endpackage

/* core/pprsp_cmd_decode.sv */
// decoder from a received command byte to a command kind
`timescale 1ns/1ns
`include "pprsp_defines.svh"
module pprsp_cmd_decode
(
  input wire logic [6:0] cmd_byte,          // logical command byte
  output pprsp_pkg::pprsp_cmd_type cmd_kind // decoded kind
);
  always_comb
  begin
    cmd_kind = pprsp_pkg::PPRSP_CMD_OTHER;
    if (cmd_byte == `PPRSP_CODE_PPC)
    begin
      cmd_kind = pprsp_pkg::PPRSP_CMD_PPC;
    end
    else if (cmd_byte == `PPRSP_CODE_PPU)
    begin
      cmd_kind = pprsp_pkg::PPRSP_CMD_PPU;
    end
    else if (cmd_byte == `PPRSP_CODE_UNL)
    begin
      cmd_kind = pprsp_pkg::PPRSP_CMD_UNL;
    end
    else if (cmd_byte == `PPRSP_CODE_PPD)
    begin
      cmd_kind = pprsp_pkg::PPRSP_CMD_PPD;
    end
    // 110_xxxx with bit 4 clear: sense and line select ride along
    else if (cmd_byte[6:4] == `PPRSP_CODE_PPE_HI)
    begin
      cmd_kind = pprsp_pkg::PPRSP_CMD_PPE;
    end
  end
endmodule

/* core/pprsp_top.sv */
// parallel poll responder with axi4-lite register access
`timescale 1ns/1ns
`include "pprsp_defines.svh"
module pprsp_top
(
  input wire logic SYS_CLK,                 // 25 mhz clock
  input wire logic SYS_RST,                 // sync reset, high
  input wire logic MASTER_RESET_N,          // master reset, low
  input wire logic ATN_N,                   // attention line
  input wire logic EOI_N,                   // end-or-identify line
  input wire logic IFC_N,                   // interface clear line
  input wire logic LISTEN_ADDRESSED,        // listener is addressed
  input wire logic BYTE_STB,                // one byte accepted
  input wire logic [7:0] DIO_IN_N,          // data lines as seen
  output logic [7:0] DIO_OUT_N,             // data line drive level
  output logic [7:0] DIO_OE,                // data line pull enable
  input wire logic S_AXI_AWVALID,           // write address valid
  output logic S_AXI_AWREADY,               // write address ready
  input wire logic [3:0] S_AXI_AWADDR,      // write address
  input wire logic [2:0] S_AXI_AWPROT,      // write protection
  input wire logic S_AXI_WVALID,            // write data valid
  output logic S_AXI_WREADY,                // write data ready
  input wire logic [31:0] S_AXI_WDATA,      // write data
  input wire logic [3:0] S_AXI_WSTRB,       // write strobes
  output logic S_AXI_BVALID,                // write response valid
  input wire logic S_AXI_BREADY,            // write response ready
  output logic [1:0] S_AXI_BRESP,           // write response
  input wire logic S_AXI_ARVALID,           // read address valid
  output logic S_AXI_ARREADY,               // read address ready
  input wire logic [3:0] S_AXI_ARADDR,      // read address
  input wire logic [2:0] S_AXI_ARPROT,      // read protection
  output logic S_AXI_RVALID,                // read data valid
  input wire logic S_AXI_RREADY,            // read data ready
  output logic [31:0] S_AXI_RDATA,          // read data
  output logic [1:0] S_AXI_RRESP            // read response
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic clear_all;
  logic cmd_take;
  logic [6:0] cmd_byte;
  pprsp_pkg::pprsp_cmd_type cmd_kind;
  pprsp_pkg::pprsp_state_type state_q;
  pprsp_pkg::pprsp_state_type state_d;
  logic armed_q;
  logic armed_d;
  logic [2:0] poll_line_select_q;
  logic [2:0] poll_line_select_d;
  logic poll_sense_bit_q;
  logic poll_sense_bit_d;
  logic [6:0] last_cmd_q;
  logic identify;
  logic idy_seen_q;
  logic status_cap_q;
  logic instrument_status_bit;
  logic status_eff;
  logic respond;
  logic poll_idle_state;
  logic [31:0] ctrl_q;
  logic aw_full_q;
  logic w_full_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic [31:0] stat_word;

  // ---------------------------------------------------------------
  // command intake
  // ---------------------------------------------------------------
  // bus lines are active low, so the logical byte is the inverse
  assign cmd_byte = ~DIO_IN_N[6:0];
  assign cmd_take = BYTE_STB & ~ATN_N;
  // only master reset feeds this term; unconfigure wipes the stored assignment in the state logic
  assign clear_all = ~MASTER_RESET_N;

  pprsp_cmd_decode u_decode
  (
    .cmd_byte(cmd_byte),
    .cmd_kind(cmd_kind)
  );

  // ---------------------------------------------------------------
  // configure-armed flag
  // ---------------------------------------------------------------
  always_comb
  begin
    armed_d = armed_q;
    if (~IFC_N)
    begin
      armed_d = 1'b0;
    end
    else if (cmd_take)
    begin
      unique case (cmd_kind)
        pprsp_pkg::PPRSP_CMD_PPC:
        begin
          armed_d = LISTEN_ADDRESSED;
        end
        pprsp_pkg::PPRSP_CMD_PPE, pprsp_pkg::PPRSP_CMD_PPD:
        begin
          // stays armed so disable may be followed by enable
          armed_d = armed_q;
        end
        pprsp_pkg::PPRSP_CMD_UNL:
        begin
          armed_d = 1'b0;
        end
        pprsp_pkg::PPRSP_CMD_PPU, pprsp_pkg::PPRSP_CMD_OTHER:
        begin
          armed_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST || clear_all)
    begin
      armed_q <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
    end
  end

  // ---------------------------------------------------------------
  // poll configuration state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    poll_line_select_d = poll_line_select_q;
    poll_sense_bit_d = poll_sense_bit_q;
    // unlisten already dropped the armed flag here
    if (cmd_take && armed_q && LISTEN_ADDRESSED)
    begin
      if (cmd_kind == pprsp_pkg::PPRSP_CMD_PPE)
      begin
        poll_line_select_d = cmd_byte[`PPRSP_PPE_SEL_HI:0];
        // kept as the pin level so the compare against the status bit is an inequality
        poll_sense_bit_d = DIO_IN_N[`PPRSP_PPE_SENSE];
        state_d = pprsp_pkg::PPRSP_ST_CONF;
      end
      else if (cmd_kind == pprsp_pkg::PPRSP_CMD_PPD)
      begin
        poll_line_select_d = 3'h0;
        poll_sense_bit_d = 1'b0;
        state_d = pprsp_pkg::PPRSP_ST_IDLE;
      end
    end
    if (cmd_take && cmd_kind == pprsp_pkg::PPRSP_CMD_PPU)
    begin
      poll_line_select_d = 3'h0;
      poll_sense_bit_d = 1'b0;
      state_d = pprsp_pkg::PPRSP_ST_IDLE;
    end
  end

  // interface clear is deliberately absent from this reset term
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST || clear_all)
    begin
      state_q <= pprsp_pkg::PPRSP_ST_IDLE;
      poll_line_select_q <= 3'h0;
      poll_sense_bit_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      poll_line_select_q <= poll_line_select_d;
      poll_sense_bit_q <= poll_sense_bit_d;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      last_cmd_q <= 7'h00;
    end
    else if (cmd_take)
    begin
      last_cmd_q <= cmd_byte;
    end
  end

  always_comb
  begin
    unique case (state_q)
      pprsp_pkg::PPRSP_ST_CONF:
      begin
        poll_idle_state = 1'b0;
      end
      pprsp_pkg::PPRSP_ST_IDLE:
      begin
        poll_idle_state = 1'b1;
      end
      default:
      begin
        poll_idle_state = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // identify response
  // ---------------------------------------------------------------
  assign identify = ~EOI_N & ~ATN_N;
  assign instrument_status_bit = ctrl_q[`PPRSP_CTRL_STATUS];

  // the live status passes through until the first edge inside the
  // poll, then the captured copy holds it; a status change in that
  // first clock period is still seen, the price of an unclocked path
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      idy_seen_q <= 1'b0;
      status_cap_q <= 1'b0;
    end
    else
    begin
      idy_seen_q <= identify;
      if (identify && !idy_seen_q)
      begin
        status_cap_q <= instrument_status_bit;
      end
    end
  end

  assign status_eff = idy_seen_q ? status_cap_q
    : instrument_status_bit;

  // no handshake: pure gating from the bus control lines
  assign respond = identify & ~poll_idle_state
    & (poll_sense_bit_q != status_eff);

  // the controller is expected to have released the lines meanwhile
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_line
      assign DIO_OUT_N[gi] = 1'b0;
      // identify ends, enable drops, line floats high
      assign DIO_OE[gi] = respond
        & (poll_line_select_q == 3'(gi));
    end
  endgenerate

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign S_AXI_AWREADY = ~aw_full_q & ~bvalid_q;
  assign S_AXI_WREADY = ~w_full_q & ~bvalid_q;
  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 4'h0;
    end
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
    end
    else if (wr_fire)
    begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_full_q <= 1'b1;
      w_data_q <= S_AXI_WDATA;
      w_strb_q <= S_AXI_WSTRB;
    end
    else if (wr_fire)
    begin
      w_full_q <= 1'b0;
    end
  end

  // only the control word is writable; other offsets answer decerr
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_q <= `PPRSP_CTRL_RST;
    end
    else if (wr_fire && aw_addr_q == `PPRSP_ADDR_CTRL && w_strb_q[0])
    begin
      ctrl_q <= {31'h0, w_data_q[`PPRSP_CTRL_STATUS]};
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `PPRSP_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      if (aw_addr_q == `PPRSP_ADDR_CTRL)
      begin
        bresp_q <= `PPRSP_RESP_OKAY;
      end
      else
      begin
        bresp_q <= `PPRSP_RESP_DECERR;
      end
    end
    else if (S_AXI_BREADY)
    begin
      bvalid_q <= 1'b0;
    end
  end

  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always_comb
  begin
    stat_word = 32'h0;
    stat_word[`PPRSP_STAT_IDLE] = poll_idle_state;
    stat_word[`PPRSP_STAT_ARMED] = armed_q;
    stat_word[`PPRSP_STAT_IDY] = identify;
    stat_word[`PPRSP_STAT_DRIVE] = respond;
    stat_word[`PPRSP_STAT_SEL_LO +: 3] = poll_line_select_q;
    stat_word[`PPRSP_STAT_SENSE] = poll_sense_bit_q;
    stat_word[`PPRSP_STAT_CAP] = status_cap_q;
  end

  assign S_AXI_ARREADY = ~rvalid_q;

  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `PPRSP_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= `PPRSP_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `PPRSP_ADDR_CTRL:
        begin
          rdata_q <= ctrl_q;
        end
        `PPRSP_ADDR_STAT:
        begin
          rdata_q <= stat_word;
        end
        `PPRSP_ADDR_LAST:
        begin
          rdata_q <= {25'h0, last_cmd_q};
        end
        default:
        begin
          rdata_q <= 32'h0;
          rresp_q <= `PPRSP_RESP_DECERR;
        end
      endcase
    end
    else if (S_AXI_RREADY)
    begin
      rvalid_q <= 1'b0;
    end
  end

  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

endmodule

/* verification/pprsp_checker_asserts.sv */
// concurrent checks on the poll responder pins
`timescale 1ns/1ns
module pprsp_checker
(
  input wire logic SYS_CLK, // clock
  input wire logic SYS_RST, // sync reset
  input wire logic MASTER_RESET_N, // master reset
  input wire logic ATN_N, // attention
  input wire logic EOI_N, // end-or-identify
  input wire logic IFC_N, // interface clear
  input wire logic LISTEN_ADDRESSED, // listening
  input wire logic BYTE_STB, // byte taken
  input wire logic [7:0] DIO_IN_N, // data lines
  input wire logic [7:0] DIO_OUT_N, // drive level
  input wire logic [7:0] DIO_OE // line pull
);
  logic armed_q;
  logic conf_q;
  logic [2:0] sel_q;
  logic [6:0] cb;
  logic cmd;
  logic ident;
  logic ok;
  assign cb = ~DIO_IN_N[6:0];
  assign cmd = BYTE_STB && !ATN_N;
  assign ident = !EOI_N && !ATN_N;
  assign ok = armed_q && LISTEN_ADDRESSED;
  // own shadow of the configuration, so the checks need no design state
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST || !MASTER_RESET_N || !IFC_N)
      armed_q <= 1'b0;
    else if (cmd)
      armed_q <= (cb == 7'h05 && LISTEN_ADDRESSED)
        || (armed_q && (cb[6:4] == 3'h6 || cb == 7'h70));
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST || !MASTER_RESET_N || (cmd && cb == 7'h15))
      conf_q <= 1'b0;
    else if (cmd && ok && cb == 7'h70)
      conf_q <= 1'b0;
    else if (cmd && ok && cb[6:4] == 3'h6)
      conf_q <= 1'b1;
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (cmd && ok && cb[6:4] == 3'h6)
      sel_q <= cb[2:0];
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_release_idle: assert property (!ident |-> DIO_OE == 8'h00)
    else $error("line pulled outside identify");
  a_one_line: assert property (DIO_OE != 8'h00 |-> $onehot(DIO_OE))
    else $error("more than one line pulled");
  a_drive_low: assert property (DIO_OE != 8'h00 |-> DIO_OUT_N == 8'h00)
    else $error("pulled line not low");
  a_sel_line: assert property (ident && DIO_OE != 8'h00
    |-> DIO_OE == (8'h01 << sel_q)) else $error("wrong line pulled");
  a_idle_quiet: assert property (!conf_q |-> DIO_OE == 8'h00)
    else $error("idle device answered");
  a_hold_poll: assert property (ident && $past(ident) && $past(ident, 2)
    && $past(MASTER_RESET_N) && !$past(BYTE_STB) |-> $stable(DIO_OE))
    else $error("response moved within identify");
  a_mreset_clear: assert property (!MASTER_RESET_N |=> DIO_OE == 8'h00)
    else $error("answer after master reset");
  a_ppu_clear: assert property (cmd && cb == 7'h15
    |=> (DIO_OE == 8'h00) [*2]) else $error("answer after unconfigure");
  c_answer: cover property (ident && DIO_OE != 8'h00);
  c_disable: cover property (cmd && ok && cb == 7'h70);
  c_ifc_kept: cover property (!IFC_N && conf_q);
endmodule
bind pprsp_top pprsp_checker u_chk (.SYS_CLK, .SYS_RST, .MASTER_RESET_N,
  .ATN_N, .EOI_N, .IFC_N, .LISTEN_ADDRESSED, .BYTE_STB, .DIO_IN_N,
  .DIO_OUT_N, .DIO_OE);

/* verification/pprsp_ctrl_model.sv */
// bus controller model: commands, identify and interface clear
`timescale 1ns/1ns
module pprsp_ctrl_model
(
  input wire logic clk, // bench clock
  output logic atn_n, // attention
  output logic eoi_n, // end-or-identify
  output logic ifc_n, // interface clear
  output logic listen, // device listen-addressed
  output logic stb, // byte strobe
  output logic [7:0] dio_n // own drive, ff is released
);
  initial
  begin
    atn_n = 1'b1;
    eoi_n = 1'b1;
    ifc_n = 1'b1;
    listen = 1'b0;
    stb = 1'b0;
    dio_n = 8'hff;
  end
  // gap lets the controller be slow between bytes
  task automatic send(input logic [6:0] b, input logic lis, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    atn_n <= 1'b0;
    listen <= lis;
    stb <= 1'b1;
    dio_n <= {1'b1, ~b};
    @(posedge clk);
    stb <= 1'b0;
    atn_n <= 1'b1;
    dio_n <= 8'hff;
  endtask
  task automatic idy(input logic on);
    @(posedge clk);
    atn_n <= !on;
    eoi_n <= !on;
    dio_n <= 8'hff;
  endtask
  task automatic clear_if();
    @(posedge clk);
    ifc_n <= 1'b0;
    @(posedge clk);
    ifc_n <= 1'b1;
  endtask
endmodule

/* verification/tb_top.sv */
// self-checking bench of the parallel poll responder
`timescale 1ns/1ns
module tb_top;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic MASTER_RESET_N = 1'b1;
  logic ATN_N, EOI_N, IFC_N, LISTEN_ADDRESSED, BYTE_STB;
  logic [7:0] DIO_IN_N, DIO_OUT_N, DIO_OE, ctrl_n;
  logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID;
  logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf;
  logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  int err_count = 0;
  int compares = 0;
  logic [2:0] cur_sel;
  logic cur_sp, cur_cfg;
  always #20 SYS_CLK = ~SYS_CLK;
  // wired-and of both parties, pull-ups when nobody pulls
  assign DIO_IN_N = ctrl_n & ~(DIO_OE & ~DIO_OUT_N);
  pprsp_top u_dut (.SYS_CLK, .SYS_RST, .MASTER_RESET_N, .ATN_N, .EOI_N,
    .IFC_N, .LISTEN_ADDRESSED, .BYTE_STB, .DIO_IN_N, .DIO_OUT_N, .DIO_OE,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_AWPROT,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY,
    .S_AXI_ARADDR, .S_AXI_ARPROT, .S_AXI_RVALID, .S_AXI_RREADY,
    .S_AXI_RDATA, .S_AXI_RRESP);
  pprsp_ctrl_model u_ctrl (.clk(SYS_CLK), .atn_n(ATN_N), .eoi_n(EOI_N),
    .ifc_n(IFC_N), .listen(LISTEN_ADDRESSED), .stb(BYTE_STB), .dio_n(ctrl_n));
  function automatic logic [7:0] exp_oe(input logic c, input logic [2:0] s,
    input logic sp, input logic st);
    return (c && sp != st) ? 8'h01 << s : 8'h00;
  endfunction
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
    input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge SYS_CLK);
    S_AXI_AWVALID <= 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WVALID <= 1'b1;
    S_AXI_WDATA <= d;
    S_AXI_BREADY <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge SYS_CLK);
      if (!aw && S_AXI_AWREADY === 1'b1)
      begin
        aw = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (!w && S_AXI_WREADY === 1'b1)
      begin
        w = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    while (S_AXI_BVALID !== 1'b1) @(posedge SYS_CLK);
    chk(S_AXI_BRESP === er, "write response");
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge SYS_CLK);
    S_AXI_ARVALID <= 1'b1;
    S_AXI_ARADDR <= a;
    S_AXI_RREADY <= 1'b1;
    do @(posedge SYS_CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge SYS_CLK); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic cfg(input logic [2:0] s, input logic sp);
    u_ctrl.send(7'h05, 1'b1, $urandom_range(2));
    u_ctrl.send({3'h6, ~sp, s}, 1'b1, $urandom_range(2));
    cur_cfg = 1'b1;
    cur_sel = s;
    cur_sp = sp;
  endtask
  // status is flipped mid-poll: the answer must not follow it
  task automatic poll(input logic st);
    logic [7:0] e;
    e = exp_oe(cur_cfg, cur_sel, cur_sp, st);
    axi_wr(4'h0, {31'h0, st}, 2'b00);
    u_ctrl.idy(1'b1);
    #1 chk(DIO_OE === e, "response not at once");
    @(posedge SYS_CLK);
    #1 chk(DIO_OE === e, "response line");
    chk(DIO_IN_N === ~e, "wire level");
    axi_wr(4'h0, {31'h0, ~st}, 2'b00);
    #1 chk(DIO_OE === e, "response moved");
    u_ctrl.idy(1'b0);
    @(posedge SYS_CLK);
    #1 chk(DIO_OE === 8'h00, "line kept");
  endtask
  initial
  begin
    #400000;
    err_count++;
    $display("Error %0t: timeout", $time);
    stop_test();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(32'h84e3d13d));
    cur_cfg = 1'b0;
    cur_sel = 3'h0;
    cur_sp = 1'b0;
    repeat (10) @(posedge SYS_CLK);
    SYS_RST <= 1'b0;
    axi_rd(4'h0, d, r);
    chk(d === 32'h0 && r === 2'b00, "ctrl reset value");
    axi_rd(4'h4, d, r);
    chk(d === 32'h1, "stat reset value");
    axi_wr(4'h4, 32'hff, 2'b11);
    axi_rd(4'hc, d, r);
    chk(d === 32'h0 && r === 2'b11, "unmapped read");
    $display("registers done");
    poll(1'b0);
    u_ctrl.send(7'h6a, 1'b1, 0);
    poll(1'b1);
    u_ctrl.send(7'h05, 1'b0, 0);
    u_ctrl.send(7'h6a, 1'b1, 0);
    poll(1'b1);
    u_ctrl.send(7'h05, 1'b1, 0);
    u_ctrl.send(7'h14, 1'b1, 0);
    u_ctrl.send(7'h6a, 1'b1, 0);
    poll(1'b1);
    $display("arming done");
    cfg(3'h7, 1'b1);
    poll(1'b0);
    for (int i = 0; i < 9; i++)
    begin
      cfg(3'($urandom), 1'($urandom));
      axi_rd(4'h4, d, r);
      chk(d[7:0] === {cur_sp, cur_sel, 4'h2}, "stored selector");
      poll(~cur_sp);
      poll(cur_sp);
    end
    $display("random polls done");
    u_ctrl.send(7'h05, 1'b1, 0);
    u_ctrl.send(7'h3f, 1'b1, 0);
    u_ctrl.send({3'h6, ~cur_sp, cur_sel + 3'h1}, 1'b1, 0);
    poll(~cur_sp);
    u_ctrl.clear_if();
    poll(~cur_sp);
    u_ctrl.send(7'h05, 1'b1, 0);
    u_ctrl.send(7'h70, 1'b1, 0);
    cur_cfg = 1'b0;
    poll(~cur_sp);
    u_ctrl.send(7'h6c, 1'b1, 0);
    cur_cfg = 1'b1;
    cur_sel = 3'h4;
    cur_sp = 1'b0;
    poll(1'b1);
    cfg(3'h5, 1'b0);
    u_ctrl.send(7'h15, 1'b0, 1);
    cur_cfg = 1'b0;
    poll(1'b1);
    cfg(3'h2, 1'b1);
    @(posedge SYS_CLK);
    MASTER_RESET_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    MASTER_RESET_N <= 1'b1;
    cur_cfg = 1'b0;
    poll(1'b0);
    axi_rd(4'h4, d, r);
    chk(d[0] === 1'b1 && d[7:4] === 4'h0, "cleared by reset");
    axi_rd(4'h8, d, r);
    chk(d === 32'h62 && r === 2'b00, "last command");
    $display("clearing done");
    stop_test();
  end
endmodule
